// ---- inc/dct_ch_if.sv ----
// Per-timer pin conditions passed from pin logic to the core
`timescale 1ns/1ps
interface dct_ch_if;
   logic ev_fall;
   logic gate_act;
   logic act_edge;
   modport src (output ev_fall, output gate_act, output act_edge);
   modport dst (input ev_fall, input gate_act, input act_edge);
endinterface : dct_ch_if

// ---- inc/dct_pkg.sv ----
// Constants and types shared by the dual counter/timer block
package dct_pkg;
   // Register offsets on the byte port
   localparam logic [7:0] OFF_CTRL = 8'h88;
   localparam logic [7:0] OFF_MODE = 8'h89;
   localparam logic [7:0] OFF_CL0 = 8'h8a;
   localparam logic [7:0] OFF_CL1 = 8'h8b;
   localparam logic [7:0] OFF_CH0 = 8'h8c;
   localparam logic [7:0] OFF_CH1 = 8'h8d;
   localparam logic [7:0] OFF_CLKSEL = 8'h8e;
   localparam logic [7:0] OFF_XCFG = 8'h8f;
   // Run, flag and type control bits
   localparam int CTRL_OVF1 = 7;
   localparam int CTRL_RUN1 = 6;
   localparam int CTRL_OVF0 = 5;
   localparam int CTRL_RUN0 = 4;
   localparam int CTRL_XF1 = 3;
   localparam int CTRL_XT1 = 2;
   localparam int CTRL_XF0 = 1;
   localparam int CTRL_XT0 = 0;
   // Mode register bits
   localparam int MODE_GATE_BIT1 = 7;
   localparam int MODE_CSRC1 = 6;
   localparam int MODE_M1_LSB = 4;
   localparam int MODE_GATE_BIT0 = 3;
   localparam int MODE_CSRC0 = 2;
   localparam int MODE_M0_LSB = 0;
   // Clock select and gate polarity bits
   localparam int CLK_PRE_LSB = 0;
   localparam int CLK_SYS0 = 3;
   localparam int CLK_SYS1 = 4;
   localparam int XCFG_POL0 = 3;
   localparam int XCFG_POL1 = 7;
   // Values after reset
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_CLKSEL = 8'h00;
   localparam logic [7:0] RST_XCFG = 8'h00;
   // Prescaler divide ratios in system clocks
   localparam logic [5:0] PRE_DIV0 = 6'h0c;
   localparam logic [5:0] PRE_DIV1 = 6'h04;
   localparam logic [5:0] PRE_DIV2 = 6'h30;
   localparam logic [5:0] PRE_DIV3 = 6'h08;

   typedef enum logic [1:0] {
      DCT_M13,
      DCT_M16,
      DCT_M8R,
      DCT_MSPLIT
   } dct_mode_t;
endpackage : dct_pkg

// ---- testbench/dct_pins_model.sv ----
// Event pin and gate input model for the counter/timer
`timescale 1ns/1ps
module dct_pins_model (
   input wire logic clock_i,
   input wire logic [1:0] go_i,
   input wire logic slow_i,
   input wire logic [1:0] gate_lvl_i,
   output logic [1:0] event_pin_o,
   output logic [1:0] gate_input_o
);
   logic [1:0] div = 2'b00;
   initial event_pin_o = 2'b11;
   assign gate_input_o = gate_lvl_i;
   always @(posedge clock_i) begin
      div <= div + 2'd1;
      for (int c = 0; c < 2; c++)
         if (!go_i[c])
            event_pin_o[c] <= 1'b1;
         else if (!slow_i || div == 2'd0)
            event_pin_o[c] <= ~event_pin_o[c];
   end
endmodule : dct_pins_model

// ---- testbench/dct_top_chk.sv ----
// Port assertions for the dual counter/timer
`timescale 1ns/1ps
module dct_top_chk (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [1:0] timer_irq_en_i,
   input wire logic [1:0] timer_irq_o,
   input wire logic t1_overflow_o
);
   logic rd_ok;
   assign rd_ok = rstn_i && ce_i && rd_i;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   a_irq0_gated:
      assert property (!timer_irq_en_i[0] |-> !timer_irq_o[0])
      else $error("irq0 without enable");
   a_irq1_gated:
      assert property (!timer_irq_en_i[1] |-> !timer_irq_o[1])
      else $error("irq1 without enable");
   a_flag0_read:
      assert property ($past(rd_ok && addr_i == 8'h88 && timer_irq_en_i[0])
         |-> rdata_o[5] == $past(timer_irq_o[0]))
      else $error("flag0 read wrong");
   a_flag1_read:
      assert property ($past(rd_ok && addr_i == 8'h88 && timer_irq_en_i[1])
         |-> rdata_o[7] == $past(timer_irq_o[1]))
      else $error("flag1 read wrong");
   a_read_slot:
      assert property ($past(ce_i && !rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside slot");
   a_unmapped_read:
      assert property ($past(rd_ok && (addr_i < 8'h88 || addr_i > 8'h8f))
         |-> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_mode_kept:
      assert property ($past(rstn_i && ce_i && wr_i && addr_i == 8'h89, 3)
         && $past(rstn_i && !wr_i, 2) && $past(rd_ok && addr_i == 8'h89)
         |-> rdata_o == $past(wdata_i, 3))
      else $error("mode readback wrong");
   a_reset_quiet:
      assert property ($rose(rstn_i) |-> !timer_irq_o && !t1_overflow_o)
      else $error("outputs busy after reset");
   c_irq0: cover property (timer_irq_o[0]);
   c_irq1: cover property (timer_irq_o[1]);
   c_t1_pulse: cover property (t1_overflow_o);
endmodule : dct_top_chk
bind dct_top dct_top_chk chk_u (.clock_i, .rstn_i, .ce_i, .addr_i, .wdata_i,
   .wr_i, .rd_i, .rdata_o, .timer_irq_en_i, .timer_irq_o, .t1_overflow_o);

// ---- testbench/tb_dct_top.sv ----
// Random and corner-case bench for the dual counter/timer
`timescale 1ns/1ps
module tb_dct_top;
   logic clock_i, rstn_i, wr_i, rd_i, t1o, slow, g;
   logic [7:0] addr_i, wdata_i, rdata_o, v, p;
   logic [1:0] ev, gt, en, ack, irq, go, glv, pv, m, xf, xa;
   logic [16:0] s, sp;
   logic [31:0] seed;
   int failures, checked, cyc, falls, t1n, n, d, f0;
   bit t;
   dct_top dut_u (.clock_i, .rstn_i, .ce_i(1'b1), .addr_i, .wdata_i, .wr_i,
      .rd_i, .rdata_o, .event_pin_i(ev), .gate_input_i(gt),
      .timer_irq_en_i(en), .timer_isr_ack_i(ack), .ext_isr_ack_i(xa),
      .timer_irq_o(irq), .ext_irq_flag_o(xf), .t1_overflow_o(t1o));
   dct_pins_model pm_u (.clock_i, .go_i(go), .slow_i(slow), .gate_lvl_i(glv),
      .event_pin_o(ev), .gate_input_o(gt));
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      pv <= ev;
      if (pv[0] && !ev[0])
         falls <= falls + 1;
      if (t1o)
         t1n <= t1n + 1;
      if (cyc == 20000) begin
         failures++;
         end_of_test();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // One increment: {flag, high, low}
   function automatic logic [16:0] step(input logic [1:0] mo,
         input logic [16:0] st);
      logic [12:0] c;
      c = {st[15:8], st[4:0]} + 13'd1;
      case (mo)
         2'd0: return {st[16] | c == 0, c[12:5], st[7:5], c[4:0]};
         2'd1: return {st[16] | &st[15:0], st[15:0] + 16'd1};
         default: return &st[7:0] ? {1'b1, st[15:8], st[15:8]}
            : {st[16], st[15:8], st[7:0] + 8'd1};
      endcase
   endfunction : step
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
         input string nm);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      addr_i <= a;
      wdata_i <= dat;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
      @(posedge clock_i);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
      @(posedge clock_i);
   endtask : rd
   task automatic end_of_test();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   initial begin
      {rstn_i, wr_i, rd_i, addr_i, wdata_i, en, ack, go, slow, xa} = '0;
      glv = 2'b11;
      pv = 2'b11;
      seed = 32'h1855b085;
      repeat (3) @(posedge clock_i);
      rstn_i <= 1'b1;
      @(posedge clock_i);
      for (int a = 8'h87; a < 8'h91; a++) begin
         rd(8'(a));
         chk(v, 16'h0000, "reset value");
      end
      wr(8'h8e, 8'h18);
      for (int i = 0; i < 40; i++) begin
         seed = xs(seed);
         t = seed[0];
         m = seed[2:1] == 2'd3 ? 2'd2 : seed[2:1];
         g = seed[3];
         p = {seed[5], 3'b000, seed[5], 3'b000};
         glv[t] <= seed[4];
         en <= seed[7:6];
         n = seed[10:8];
         s = {1'b0, seed[11] ? 8'hff : seed[31:24], seed[23:16] | 8'hf0};
         wr(8'h8f, p);
         wr(8'h89, t ? {g, 1'b0, m, 4'h0} : {4'h0, g, 1'b0, m});
         rd(8'h89);
         chk(v, t ? {g, 1'b0, m, 4'h0} : {4'h0, g, 1'b0, m}, "mode");
         wr({7'h45, t}, s[7:0]);
         wr({7'h46, t}, s[15:8]);
         wr(8'h88, 8'h00);
         sp = s;
         for (int k = 0; k < n + 2; k++) begin
            if (!g || seed[4] == seed[5])
               s = step(m, s);
            if (k == n)
               sp = s;
         end
         wr(8'h88, t ? 8'h40 : 8'h10);
         repeat (n) @(posedge clock_i);
         wr(8'h88, {sp[16] & t, 1'b0, sp[16] & !t, 5'h00});
         rd({7'h45, t});
         chk(v, s[7:0], "low");
         rd({7'h46, t});
         chk(v, s[15:8], "high");
         rd(8'h88);
         chk(v & 8'hf0, {s[16] & t, 1'b0, s[16] & !t, 5'h00}, "ctrl");
         ack[t] <= 1'b1;
         #1 chk(irq[t], s[16] & en[t], "irq");
         @(posedge clock_i);
         ack <= 2'b00;
         @(posedge clock_i);
         #1 chk(irq, 2'b00, "ack");
         @(posedge clock_i);
      end
      wr(8'h89, 8'h05);
      wr(8'h8a, 8'h00);
      wr(8'h8c, 8'h00);
      wr(8'h88, 8'h10);
      f0 = falls;
      go <= 2'b01;
      slow <= seed[0];
      repeat (24) @(posedge clock_i);
      go <= 2'b00;
      repeat (3) @(posedge clock_i);
      wr(8'h88, 8'h00);
      rd(8'h8a);
      chk(v, 16'(falls - f0), "events");
      for (int q = 0; q < 4; q++) begin
         d = q == 0 ? 12 : q == 1 ? 4 : q == 2 ? 48 : 8;
         wr(8'h8e, 8'(q));
         wr(8'h89, 8'h01);
         wr(8'h8a, 8'h00);
         wr(8'h88, 8'h10);
         repeat (96) @(posedge clock_i);
         wr(8'h88, 8'h00);
         rd(8'h8a);
         chk(v == 98 / d || v == 97 / d + 1, 16'h0001, "scaled");
      end
      wr(8'h8e, 8'h18);
      wr(8'h89, 8'h23);
      wr(8'h8d, 8'hff);
      n = t1n;
      repeat (270) @(posedge clock_i);
      rd(8'h88);
      chk(v[7], 16'h0000, "t1 flag");
      chk(t1n > n, 16'h0001, "t1 pulse");
      wr(8'h89, 8'h33);
      wr(8'h8b, 8'h05);
      repeat (4) @(posedge clock_i);
      rd(8'h8b);
      chk(v, 16'h0005, "t1 off");
      wr(8'h8a, 8'h10);
      wr(8'h8c, 8'hff);
      wr(8'h88, 8'h50);
      wr(8'h88, 8'h80);
      rd(8'h8a);
      chk(v, 16'h0012, "split low");
      rd(8'h8c);
      chk(v, 16'h0001, "split high");
      rd(8'h88);
      chk(v & 8'hf0, 16'h0080, "split flag");
      wr(8'h8f, 8'h88);
      glv <= 2'b11;
      wr(8'h88, 8'h00);
      chk(xf, 16'h0003, "level on");
      glv <= 2'b00;
      repeat (2) @(posedge clock_i);
      chk(xf, 16'h0000, "level off");
      wr(8'h88, 8'h05);
      glv <= 2'b11;
      repeat (2) @(posedge clock_i);
      glv <= 2'b00;
      repeat (2) @(posedge clock_i);
      chk(xf, 16'h0003, "edge kept");
      xa <= 2'b11;
      @(posedge clock_i);
      xa <= 2'b00;
      @(posedge clock_i);
      chk(xf, 16'h0000, "edge cleared");
      end_of_test();
   end
endmodule : tb_dct_top

// ---- verilog/dct_pin.sv ----
// Event pin edge and gate input conditioning for one timer
`timescale 1ns/1ps
module dct_pin (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic event_pin_i,
   input wire logic gate_input_i,
   input wire logic gate_polarity_i,
   dct_ch_if.src ch
);
   typedef struct packed {
      logic pin_q;
      logic act_q;
   } dct_pin_st_t;

   dct_pin_st_t q;
   dct_pin_st_t next_q;
   logic act;

   // Active level set by polarity: 1 means active high
   assign act = ~(gate_input_i ^ gate_polarity_i);

   always_comb begin
      next_q = q;
      next_q.pin_q = event_pin_i;
      next_q.act_q = act;
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= next_q;
      end
   end

   // High-to-low transition on the event pin
   assign ch.ev_fall = ce_i & q.pin_q & ~event_pin_i;
   assign ch.gate_act = act;
   assign ch.act_edge = ce_i & act & ~q.act_q;
endmodule : dct_pin

// ---- verilog/dct_prescale.sv ----
// Prescaled clock tick generator
`timescale 1ns/1ps
module dct_prescale (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic [1:0] prescale_i,
   output logic tick_o
);
   typedef struct packed {
      logic [5:0] cnt;
      logic tick;
   } dct_pre_st_t;

   dct_pre_st_t q;
   dct_pre_st_t next_q;
   logic [5:0] div;

   always_comb begin
      unique case (prescale_i)
         2'h0: div = dct_pkg::PRE_DIV0;
         2'h1: div = dct_pkg::PRE_DIV1;
         2'h2: div = dct_pkg::PRE_DIV2;
         2'h3: div = dct_pkg::PRE_DIV3;
      endcase
      next_q = q;
      next_q.tick = 1'b0;
      if (q.cnt >= div - 6'h01) begin
         next_q.cnt = 6'h00;
         next_q.tick = 1'b1;
      end else begin
         next_q.cnt = q.cnt + 6'h01;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= next_q;
      end
   end

   assign tick_o = q.tick;
endmodule : dct_prescale

// ---- verilog/dct_top.sv ----
// Dual counter/timer with four modes and byte register port
// Function
// (RQ1) Count-source 1: count event pin falling edges
// (RQ2) Count-source 0: system or prescaled clock
// (RQ3) Count when run and (no gate or gate)
// (RQ4) Gate active level set by per-input polarity
// (RQ5) Setting run keeps the current count
// (RQ6) Timer 1 mirrors timer 0 with own controls
// (RQ7) 13-bit mode: high byte plus low five
// (RQ8) 16-bit mode uses both count bytes
// (RQ9) 8-bit mode reloads low from high byte
// (RQ10) Software preloads low byte before auto-reload
// (RQ11) Flag and enable raise timer interrupt request
// (RQ12) Split: low byte uses timer 0 controls
// (RQ13) Split: high byte on run1, sets flag1
// (RQ14) Split: timer 1 internal only, no flag
// (RQ15) Split: timer 1 runs unless mode three
// (RQ16) Mode field picks 13/16/reload/split-or-off
// (RQ17) Flag set by overflow, cleared by software/vector
// (RQ18) Type bit picks edge or level external flag
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module dct_top (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic [1:0] event_pin_i,
   input wire logic [1:0] gate_input_i,
   input wire logic [1:0] timer_irq_en_i,
   input wire logic [1:0] timer_isr_ack_i,
   input wire logic [1:0] ext_isr_ack_i,
   output logic [1:0] timer_irq_o,
   output logic [1:0] ext_irq_flag_o,
   output logic t1_overflow_o
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] mode;
      logic [7:0] cl0;
      logic [7:0] ch0;
      logic [7:0] cl1;
      logic [7:0] ch1;
      logic [7:0] clksel;
      logic [7:0] xcfg;
      logic [7:0] rdata;
      logic t1_ovf;
   } dct_st_t;

   dct_st_t q;
   dct_st_t next_q;
   logic pre_tick;
   logic [1:0] pol;
   dct_ch_if chx[2] ();

   assign pol = {q.xcfg[dct_pkg::XCFG_POL1], q.xcfg[dct_pkg::XCFG_POL0]};

   // (RQ4) per-input polarity
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pin
         dct_pin u_pin (
            .clock_i(clock_i),
            .rstn_i(rstn_i),
            .ce_i(ce_i),
            .event_pin_i(event_pin_i[g]),
            .gate_input_i(gate_input_i[g]),
            .gate_polarity_i(pol[g]),
            .ch(chx[g].src)
         );
      end
   endgenerate

   dct_prescale u_pre (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .prescale_i(q.clksel[dct_pkg::CLK_PRE_LSB +: 2]),
      .tick_o(pre_tick)
   );

   // One increment step: {overflow, high, low}
   function automatic logic [16:0] dct_step(
      input dct_pkg::dct_mode_t m,
      input logic [7:0] lo,
      input logic [7:0] hi
   );
      logic [5:0] l5;
      logic [8:0] s;
      logic [16:0] r;
      l5 = 6'h00;
      s = 9'h000;
      r = {1'b0, hi, lo};
      unique case (m)
         // (RQ7) five low bits carry into high byte
         dct_pkg::DCT_M13: begin
            l5 = {1'b0, lo[4:0]} + 6'h01;
            s = {1'b0, hi} + {8'h00, l5[5]};
            r = {s[8], s[7:0], lo[7:5], l5[4:0]};
         end
         // (RQ8) full sixteen bits
         dct_pkg::DCT_M16: begin
            r = {1'b0, hi, lo} + 17'h00001;
         end
         // (RQ9) reload low from unchanged high
         dct_pkg::DCT_M8R: begin
            s = {1'b0, lo} + 9'h001;
            r = {s[8], hi, s[8] ? hi : s[7:0]};
         end
         // (RQ12) split low byte counts alone
         dct_pkg::DCT_MSPLIT: begin
            s = {1'b0, lo} + 9'h001;
            r = {s[8], hi, s[7:0]};
         end
      endcase
      return r;
   endfunction : dct_step

   dct_pkg::dct_mode_t mode0;
   dct_pkg::dct_mode_t mode1;
   logic split;
   logic tick0;
   logic tick1;
   logic en0;
   logic en1;
   logic inc0;
   logic inc1;
   logic [16:0] r0;
   logic [16:0] r1;
   logic [8:0] sh;
   logic th_inc;
   logic ovf0_set;
   logic ovf1_raw;
   logic ovf1_set;
   logic wr_ctrl;
   logic [7:0] base;

   always_comb begin
      next_q = q;
      next_q.rdata = 8'h00;
      next_q.t1_ovf = 1'b0;
      mode0 = dct_pkg::dct_mode_t'(q.mode[dct_pkg::MODE_M0_LSB +: 2]);
      mode1 = dct_pkg::dct_mode_t'(q.mode[dct_pkg::MODE_M1_LSB +: 2]);
      split = (mode0 == dct_pkg::DCT_MSPLIT);

      // (RQ1) event pin falling edges
      // (RQ2) system clock or prescaled tick
      tick0 = q.mode[dct_pkg::MODE_CSRC0] ? chx[0].ev_fall
            : (q.clksel[dct_pkg::CLK_SYS0] | pre_tick);
      // (RQ14) no external edges while split
      tick1 = (q.mode[dct_pkg::MODE_CSRC1] & ~split) ? chx[1].ev_fall
            : (q.clksel[dct_pkg::CLK_SYS1] | pre_tick);

      // (RQ3) run and gate qualify counting
      en0 = q.ctrl[dct_pkg::CTRL_RUN0]
         & (~q.mode[dct_pkg::MODE_GATE_BIT0] | chx[0].gate_act);
      // (RQ15) split: mode field runs timer 1
      if (split) begin
         en1 = (mode1 != dct_pkg::DCT_MSPLIT);
      end else begin
         // (RQ6) same qualifiers, own bits
         en1 = q.ctrl[dct_pkg::CTRL_RUN1]
            & (~q.mode[dct_pkg::MODE_GATE_BIT1] | chx[1].gate_act)
            & (mode1 != dct_pkg::DCT_MSPLIT);
      end
      inc0 = en0 & tick0;
      inc1 = en1 & tick1;

      // (RQ16) mode field selects behaviour
      r0 = dct_step(mode0, q.cl0, q.ch0);
      r1 = dct_step(mode1, q.cl1, q.ch1);

      // (RQ5) counting continues from held value
      ovf0_set = inc0 & r0[16];
      if (inc0) begin
         next_q.cl0 = r0[7:0];
         if (!split) begin
            next_q.ch0 = r0[15:8];
         end
      end

      // (RQ13) high byte on run1, internal clock
      th_inc = split & q.ctrl[dct_pkg::CTRL_RUN1]
            & (q.clksel[dct_pkg::CLK_SYS1] | pre_tick);
      sh = {1'b0, q.ch0} + 9'h001;
      if (th_inc) begin
         next_q.ch0 = sh[7:0];
      end

      ovf1_raw = inc1 & r1[16];
      if (inc1) begin
         next_q.cl1 = r1[7:0];
         next_q.ch1 = r1[15:8];
      end
      // (RQ14) pulse still reaches consumers
      next_q.t1_ovf = ovf1_raw;
      // (RQ13) high byte overflow drives flag 1
      ovf1_set = split ? (th_inc & sh[8]) : ovf1_raw;

      // Register writes win over counting
      wr_ctrl = wr_i & (addr_i == dct_pkg::OFF_CTRL);
      base = wr_ctrl ? wdata_i : q.ctrl;
      next_q.ctrl = base;
      if (wr_i) begin
         unique case (addr_i)
            dct_pkg::OFF_MODE: next_q.mode = wdata_i;
            dct_pkg::OFF_CL0: next_q.cl0 = wdata_i;
            dct_pkg::OFF_CH0: next_q.ch0 = wdata_i;
            dct_pkg::OFF_CL1: next_q.cl1 = wdata_i;
            dct_pkg::OFF_CH1: next_q.ch1 = wdata_i;
            dct_pkg::OFF_CLKSEL: next_q.clksel = wdata_i;
            dct_pkg::OFF_XCFG: next_q.xcfg = wdata_i;
            default: ;
         endcase
      end

      // (RQ17) set wins over clear
      next_q.ctrl[dct_pkg::CTRL_OVF0] = ovf0_set
         | (base[dct_pkg::CTRL_OVF0] & ~timer_isr_ack_i[0]);
      next_q.ctrl[dct_pkg::CTRL_OVF1] = ovf1_set
         | (base[dct_pkg::CTRL_OVF1] & ~timer_isr_ack_i[1]);

      // (RQ18) edge sets sticky flag, level follows
      if (q.ctrl[dct_pkg::CTRL_XT0]) begin
         next_q.ctrl[dct_pkg::CTRL_XF0] = chx[0].act_edge
            | (base[dct_pkg::CTRL_XF0] & ~ext_isr_ack_i[0]);
      end else begin
         next_q.ctrl[dct_pkg::CTRL_XF0] = chx[0].gate_act;
      end
      if (q.ctrl[dct_pkg::CTRL_XT1]) begin
         next_q.ctrl[dct_pkg::CTRL_XF1] = chx[1].act_edge
            | (base[dct_pkg::CTRL_XF1] & ~ext_isr_ack_i[1]);
      end else begin
         next_q.ctrl[dct_pkg::CTRL_XF1] = chx[1].gate_act;
      end

      // Read data stands one cycle only
      if (rd_i) begin
         unique case (addr_i)
            dct_pkg::OFF_CTRL: next_q.rdata = q.ctrl;
            dct_pkg::OFF_MODE: next_q.rdata = q.mode;
            dct_pkg::OFF_CL0: next_q.rdata = q.cl0;
            dct_pkg::OFF_CH0: next_q.rdata = q.ch0;
            dct_pkg::OFF_CL1: next_q.rdata = q.cl1;
            dct_pkg::OFF_CH1: next_q.rdata = q.ch1;
            dct_pkg::OFF_CLKSEL: next_q.rdata = q.clksel;
            dct_pkg::OFF_XCFG: next_q.rdata = q.xcfg;
            default: next_q.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         q.ctrl <= dct_pkg::RST_CTRL;
         q.mode <= dct_pkg::RST_MODE;
         q.cl0 <= dct_pkg::RST_COUNT;
         q.ch0 <= dct_pkg::RST_COUNT;
         q.cl1 <= dct_pkg::RST_COUNT;
         q.ch1 <= dct_pkg::RST_COUNT;
         q.clksel <= dct_pkg::RST_CLKSEL;
         q.xcfg <= dct_pkg::RST_XCFG;
         q.rdata <= 8'h00;
         q.t1_ovf <= 1'b0;
      end else if (ce_i) begin
         q <= next_q;
      end
   end

   // (RQ11) flag gated by interrupt enable
   assign timer_irq_o[0] = q.ctrl[dct_pkg::CTRL_OVF0] & timer_irq_en_i[0];
   assign timer_irq_o[1] = q.ctrl[dct_pkg::CTRL_OVF1] & timer_irq_en_i[1];
   assign ext_irq_flag_o = {q.ctrl[dct_pkg::CTRL_XF1],
                            q.ctrl[dct_pkg::CTRL_XF0]};
   assign rdata_o = q.rdata;
   assign t1_overflow_o = q.t1_ovf;
endmodule : dct_top
